// [hdl/ses_pkg.sv]
// Package of offsets, field positions, reset values and states of the standby exit sequencer
package ses_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFF_STBY_CTRL = 8'h00;
    localparam logic [7:0] OFF_INT_CTRL  = 8'h04;
    localparam logic [7:0] OFF_WDT_CSR   = 8'h08;
    localparam logic [7:0] OFF_WDT_CNT   = 8'h0c;
    localparam logic [7:0] OFF_CMD       = 8'h10;
    localparam logic [7:0] OFF_STATUS    = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h1c;
    localparam logic [7:0] OFF_PORT_DATA = 8'h20;
    localparam logic [7:0] OFF_PIN_FUNC  = 8'h24;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_STBY_REQ   = 0;
    localparam int BIT_EDGE_POL   = 0;
    localparam int BIT_WDT_OVF    = 7;
    localparam int BIT_WDT_MODE   = 6;
    localparam int BIT_WDT_RUN    = 5;
    localparam int BIT_CMD_SLEEP  = 0;
    localparam int BIT_CMD_MRES   = 1;
    localparam int BIT_IRQ_NMI    = 0;
    localparam int BIT_IRQ_WAKE   = 1;
    localparam int BIT_IRQ_WOVF   = 2;
    localparam int BIT_IRQ_RESET  = 3;
    localparam int IRQ_W          = 4;
    localparam int CKS_W          = 3;
    localparam int CNT_W          = 8;
    localparam int PRE_W          = 15;

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [CKS_W-1:0] RST_CKS     = 3'h0;
    localparam logic [CNT_W-1:0] RST_CNT     = 8'h00;
    localparam logic [PRE_W-1:0] RST_PRE     = 15'h0000;
    localparam logic [31:0]      RST_WORD    = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] RST_IRQ     = 4'h0;

    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_STANDBY = 2'b01,
        ST_SETTLE  = 2'b10
    } ses_state_e;

endpackage

// [hdl/ses_wdt_if.sv]
// Interface between the sequencer and its watchdog counter
interface ses_wdt_if;
    logic [2:0] clkSel;
    logic       count;
    logic       cntWr;
    logic [7:0] cntWrData;
    logic [7:0] cnt;
    logic       ovfPulse;

    modport ctrl (output clkSel, output count, output cntWr, output cntWrData,
                  input cnt, input ovfPulse);
    modport wdt  (input clkSel, input count, input cntWr, input cntWrData,
                  output cnt, output ovfPulse);
endinterface

// [hdl/ses_wdt.sv]
// Watchdog counter with clock-select prescaler, used as the settling timer
module ses_wdt (
    input wire logic clk_sys,
    input wire logic rst_b,
    ses_wdt_if.wdt   w
);

    // ************************************************************
    // Prescaler tap decode
    // ************************************************************
    // Larger select values stretch the overflow period by four per step
    function automatic logic [ses_pkg::PRE_W-1:0] tapMask(input logic [2:0] sel);
        logic [ses_pkg::PRE_W:0] one;
        one = {{ses_pkg::PRE_W{1'b0}}, 1'b1};
        tapMask = ses_pkg::PRE_W'((one << ({1'b0, sel, 1'b0} + 5'd1)) - 1'b1);
    endfunction

    logic [ses_pkg::PRE_W-1:0] pre_r;
    logic [ses_pkg::CNT_W-1:0] cnt_r;
    logic                      ovf_r;
    logic                      tick;

    assign tick       = w.count && ((pre_r & tapMask(w.clkSel)) == tapMask(w.clkSel));
    assign w.cnt      = cnt_r;
    assign w.ovfPulse = ovf_r;

    // ************************************************************
    // Prescaler
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pre_r <= ses_pkg::RST_PRE;
        end else if (w.count) begin
            pre_r <= pre_r + 1'b1;
        end else begin
            pre_r <= ses_pkg::RST_PRE;
        end
    end

    // ************************************************************
    // Counter and overflow
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= ses_pkg::RST_CNT;
            ovf_r <= 1'b0;
        end else begin
            ovf_r <= tick && (cnt_r == 8'hff);
            if (w.cntWr) begin
                cnt_r <= w.cntWrData;
            end else if (tick) begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

endmodule

// [hdl/ses_sequencer.sv]
// Standby exit sequencer: standby entry, wake sources, clock gating and register bus
//
// Operation
// R1: Standby ends on accepted interrupt pin edge, power-on reset or manual reset.
// R2: In standby, the selected interrupt pin edge restarts the oscillator.
// R3: While settling, the clock reaches only the watchdog, not the chip.
// R4: Watchdog overflow means clock stable: feed chip, leave standby, start exception.
// R5: Firmware picks a clock select giving overflow longer than oscillator settling.
// R6: Falling-edge wake: pin high at standby entry, low when clock resumes.
// R7: Rising-edge wake: pin low at standby entry, high when clock resumes.
// R8: Reset pin low gives power-on reset that ends standby at once.
// R9: Edge polarity bit zero selects falling edge, one selects rising edge.
// R10: Sleep command with standby request bit set enters standby.
// R11: Port, pin function and standby control registers keep values across standby.
// R12: Standby entry clears watchdog overflow, mode and run bits; select and count kept.
module ses_sequencer (
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        nmiPin,
    input  wire logic        powerOnResetPin_b,
    input  wire logic        manualResetPin_b,
    output logic             oscEnable,
    output logic             wdtClkEn,
    output logic             chipClkEn,
    output logic             standbyActive,
    output logic             nmiExcStart,
    output logic             irq,
    output logic [31:0]      portOut,
    output logic [31:0]      pinFuncOut
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [1:0] nmiSync_r;
    logic [1:0] porSync_r;
    logic [1:0] mresSync_r;
    logic       nmiPrev_r;
    logic       porReq;
    logic       mresReq;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            nmiSync_r  <= 2'h0;
            porSync_r  <= 2'h3;
            mresSync_r <= 2'h3;
        end else begin
            nmiSync_r  <= {nmiSync_r[0], nmiPin};
            porSync_r  <= {porSync_r[0], powerOnResetPin_b};
            mresSync_r <= {mresSync_r[0], manualResetPin_b};
        end
    end

    // The previous level resets low, so a pin held high through release gives one rising edge
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            nmiPrev_r <= 1'b0;
        end else begin
            nmiPrev_r <= nmiSync_r[1];
        end
    end

    assign porReq  = !porSync_r[1];
    assign mresReq = !mresSync_r[1];

    // ************************************************************
    // Bus address phase capture
    // ************************************************************
    logic       wrPend_r;
    logic       rdPend_r;
    logic [7:0] addr_r;
    logic       accept;

    assign accept = hsel && hready && htrans[1];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wrPend_r <= 1'b0;
            rdPend_r <= 1'b0;
            addr_r   <= 8'h00;
        end else begin
            wrPend_r <= accept && hwrite;
            rdPend_r <= accept && !hwrite;
            if (accept) begin
                addr_r <= {haddr[7:2], 2'b00};
            end
        end
    end

    function automatic logic isWr(input logic pend, input logic [7:0] a,
                                  input logic [7:0] off);
        isWr = pend && (a == off);
    endfunction

    // ************************************************************
    // Registers
    // ************************************************************
    logic                             stbyReq_r;
    logic                             edgePol_r;
    logic                             wdtOvf_r;
    logic                             wdtMode_r;
    logic                             wdtRun_r;
    logic [ses_pkg::CKS_W-1:0]        wdtSel_r;
    logic [ses_pkg::IRQ_W-1:0]        irqStat_r;
    logic [ses_pkg::IRQ_W-1:0]        irqMask_r;
    logic [31:0]                      port_r;
    logic [31:0]                      pinFunc_r;
    logic                             sleepCmd;
    logic                             mresCmd;
    logic                             nmiEdge;
    logic                             enterStby;
    logic                             wakeDone;
    logic [ses_pkg::IRQ_W-1:0]        irqSet;
    ses_pkg::ses_state_e              state_r;
    ses_pkg::ses_state_e              state_nxt;
    ses_wdt_if                        wdtIf ();

    assign sleepCmd = isWr(wrPend_r, addr_r, ses_pkg::OFF_CMD)
                      && hwdata[ses_pkg::BIT_CMD_SLEEP];
    assign mresCmd  = isWr(wrPend_r, addr_r, ses_pkg::OFF_CMD)
                      && hwdata[ses_pkg::BIT_CMD_MRES];

    // Polarity zero accepts high to low, one accepts low to high
    assign nmiEdge = edgePol_r ? (nmiSync_r[1] && !nmiPrev_r)        // R9
                               : (!nmiSync_r[1] && nmiPrev_r);       // R9

    assign enterStby = (state_r == ses_pkg::ST_RUN) && sleepCmd && stbyReq_r;  // R10
    assign wakeDone  = (state_r == ses_pkg::ST_SETTLE) && wdtIf.ovfPulse;      // R4

    // Standby control and polarity survive standby; only a power-on reset clears them
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            stbyReq_r <= 1'b0;
            edgePol_r <= 1'b0;
        end else if (porReq) begin
            stbyReq_r <= 1'b0;
            edgePol_r <= 1'b0;
        end else begin
            if (isWr(wrPend_r, addr_r, ses_pkg::OFF_STBY_CTRL)) begin
                stbyReq_r <= hwdata[ses_pkg::BIT_STBY_REQ];                    // R11
            end
            if (isWr(wrPend_r, addr_r, ses_pkg::OFF_INT_CTRL)) begin
                edgePol_r <= hwdata[ses_pkg::BIT_EDGE_POL];
            end
        end
    end

    // Port and pin function contents are not touched by standby entry or exit
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            port_r    <= ses_pkg::RST_WORD;
            pinFunc_r <= ses_pkg::RST_WORD;
        end else if (porReq) begin
            port_r    <= ses_pkg::RST_WORD;
            pinFunc_r <= ses_pkg::RST_WORD;
        end else begin
            if (isWr(wrPend_r, addr_r, ses_pkg::OFF_PORT_DATA)) begin
                port_r <= hwdata;                                            // R11
            end
            if (isWr(wrPend_r, addr_r, ses_pkg::OFF_PIN_FUNC)) begin
                pinFunc_r <= hwdata;                                         // R11
            end
        end
    end

    // ************************************************************
    // Watchdog control and status
    // ************************************************************
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wdtOvf_r  <= 1'b0;
            wdtMode_r <= 1'b0;
            wdtRun_r  <= 1'b0;
            wdtSel_r  <= ses_pkg::RST_CKS;
        end else if (porReq) begin
            wdtOvf_r  <= 1'b0;
            wdtMode_r <= 1'b0;
            wdtRun_r  <= 1'b0;
            wdtSel_r  <= ses_pkg::RST_CKS;
        end else if (enterStby) begin
            wdtOvf_r  <= 1'b0;                                               // R12
            wdtMode_r <= 1'b0;                                               // R12
            wdtRun_r  <= 1'b0;                                               // R12
        end else begin
            if (isWr(wrPend_r, addr_r, ses_pkg::OFF_WDT_CSR)) begin
                wdtMode_r <= hwdata[ses_pkg::BIT_WDT_MODE];
                wdtRun_r  <= hwdata[ses_pkg::BIT_WDT_RUN];
                wdtSel_r  <= hwdata[ses_pkg::CKS_W-1:0];                       // R5
            end
            // Overflow in normal run sets the flag; writing zero clears, set wins
            if (wdtIf.ovfPulse && (state_r == ses_pkg::ST_RUN)) begin
                wdtOvf_r <= 1'b1;
            end else if (isWr(wrPend_r, addr_r, ses_pkg::OFF_WDT_CSR)
                         && !hwdata[ses_pkg::BIT_WDT_OVF]) begin
                wdtOvf_r <= 1'b0;
            end
        end
    end

    // Settling reuses the counter value left in place before standby
    assign wdtIf.clkSel    = wdtSel_r;
    assign wdtIf.count     = (state_r == ses_pkg::ST_SETTLE)                  // R3
                             || ((state_r == ses_pkg::ST_RUN) && wdtRun_r);
    assign wdtIf.cntWr     = isWr(wrPend_r, addr_r, ses_pkg::OFF_WDT_CNT) && !porReq;
    assign wdtIf.cntWrData = hwdata[ses_pkg::CNT_W-1:0];

    ses_wdt u_wdt (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .w       (wdtIf.wdt)
    );

    // ************************************************************
    // Standby state machine
    // ************************************************************
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ses_pkg::ST_RUN: begin
                if (enterStby) begin
                    state_nxt = ses_pkg::ST_STANDBY;                         // R10
                end
            end
            ses_pkg::ST_STANDBY: begin
                // Pin levels around entry are the source's duty; only a true edge wakes
                if (nmiEdge) begin                                           // R6 R7
                    state_nxt = ses_pkg::ST_SETTLE;                          // R2
                end
            end
            ses_pkg::ST_SETTLE: begin
                if (wdtIf.ovfPulse) begin
                    state_nxt = ses_pkg::ST_RUN;                             // R4
                end
            end
            default: begin
                state_nxt = ses_pkg::ST_RUN;
            end
        endcase
        if (porReq || mresReq || mresCmd) begin
            state_nxt = ses_pkg::ST_RUN;                                     // R1 R8
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= ses_pkg::ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Clock gating outputs follow the next state so they change with the state
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            oscEnable     <= 1'b1;
            wdtClkEn      <= 1'b1;
            chipClkEn     <= 1'b1;
            standbyActive <= 1'b0;
            nmiExcStart   <= 1'b0;
        end else begin
            oscEnable     <= (state_nxt != ses_pkg::ST_STANDBY);             // R2
            wdtClkEn      <= (state_nxt != ses_pkg::ST_STANDBY);             // R3
            chipClkEn     <= (state_nxt == ses_pkg::ST_RUN);                 // R3 R4
            standbyActive <= (state_nxt != ses_pkg::ST_RUN);
            nmiExcStart   <= (wakeDone && !porReq && !mresReq && !mresCmd)  // R4
                             || ((state_r == ses_pkg::ST_RUN) && nmiEdge && !porReq && !enterStby);
        end
    end

    // ************************************************************
    // Interrupt status and mask
    // ************************************************************
    always_comb begin
        irqSet = ses_pkg::RST_IRQ;
        irqSet[ses_pkg::BIT_IRQ_NMI]   = (state_r == ses_pkg::ST_RUN) && nmiEdge;
        irqSet[ses_pkg::BIT_IRQ_WAKE]  = wakeDone;
        irqSet[ses_pkg::BIT_IRQ_WOVF]  = wdtIf.ovfPulse && (state_r == ses_pkg::ST_RUN);
        irqSet[ses_pkg::BIT_IRQ_RESET] = (mresReq || mresCmd) && (state_r != ses_pkg::ST_RUN);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irqStat_r <= ses_pkg::RST_IRQ;
            irqMask_r <= ses_pkg::RST_IRQ;
        end else if (porReq) begin
            irqStat_r <= ses_pkg::RST_IRQ;
            irqMask_r <= ses_pkg::RST_IRQ;
        end else begin
            if (isWr(wrPend_r, addr_r, ses_pkg::OFF_IRQ_STAT)) begin
                irqStat_r <= (irqStat_r & ~hwdata[ses_pkg::IRQ_W-1:0]) | irqSet;
            end else begin
                irqStat_r <= irqStat_r | irqSet;
            end
            if (isWr(wrPend_r, addr_r, ses_pkg::OFF_IRQ_MASK)) begin
                irqMask_r <= hwdata[ses_pkg::IRQ_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irqStat_r & irqMask_r);
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // One wait state on reads so a write just before is always visible
    logic [31:0] rdVal;

    always_comb begin
        rdVal = ses_pkg::RST_WORD;
        if (addr_r == ses_pkg::OFF_STBY_CTRL) begin
            rdVal[ses_pkg::BIT_STBY_REQ] = stbyReq_r;
        end else if (addr_r == ses_pkg::OFF_INT_CTRL) begin
            rdVal[ses_pkg::BIT_EDGE_POL] = edgePol_r;
        end else if (addr_r == ses_pkg::OFF_WDT_CSR) begin
            rdVal[ses_pkg::BIT_WDT_OVF]   = wdtOvf_r;
            rdVal[ses_pkg::BIT_WDT_MODE]  = wdtMode_r;
            rdVal[ses_pkg::BIT_WDT_RUN]   = wdtRun_r;
            rdVal[ses_pkg::CKS_W-1:0]     = wdtSel_r;
        end else if (addr_r == ses_pkg::OFF_WDT_CNT) begin
            rdVal[ses_pkg::CNT_W-1:0] = wdtIf.cnt;
        end else if (addr_r == ses_pkg::OFF_STATUS) begin
            rdVal[1:0] = state_r;
            rdVal[2]   = nmiSync_r[1];
        end else if (addr_r == ses_pkg::OFF_IRQ_STAT) begin
            rdVal[ses_pkg::IRQ_W-1:0] = irqStat_r;
        end else if (addr_r == ses_pkg::OFF_IRQ_MASK) begin
            rdVal[ses_pkg::IRQ_W-1:0] = irqMask_r;
        end else if (addr_r == ses_pkg::OFF_PORT_DATA) begin
            rdVal = port_r;
        end else if (addr_r == ses_pkg::OFF_PIN_FUNC) begin
            rdVal = pinFunc_r;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hreadyout <= 1'b1;
            hrdata    <= ses_pkg::RST_WORD;
        end else begin
            hreadyout <= !(accept && !hwrite);
            if (rdPend_r) begin
                hrdata <= rdVal;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hresp      <= 1'b0;
            portOut    <= ses_pkg::RST_WORD;
            pinFuncOut <= ses_pkg::RST_WORD;
        end else begin
            hresp      <= 1'b0;
            portOut    <= port_r;
            pinFuncOut <= pinFunc_r;
        end
    end

endmodule

// [bench/ses_pin_src.sv]
// Behavioural source for the interrupt pin and both reset pins
module ses_pin_src (
    input  wire logic clk_sys,
    input  wire logic pol,
    input  wire logic fire,
    input  wire logic por,
    input  wire logic mres,
    output logic      nmiPin,
    output logic      powerOnResetPin_b,
    output logic      manualResetPin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Pin levels
    // ****************************************
    // Pin rests at the inactive level, so the only edge seen in standby is the wake edge
    assign nmiPin            = fire ? pol : !pol;
    assign powerOnResetPin_b = !por;
    assign manualResetPin_b  = !mres;
endmodule

// [bench/ses_sequencer_asserts.sv]
// Concurrent checks on the standby exit sequencer ports
module ses_sequencer_asserts (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic oscEnable,
    input wire logic wdtClkEn,
    input wire logic chipClkEn,
    input wire logic standbyActive,
    input wire logic nmiExcStart,
    input wire logic powerOnResetPin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Five samples cover the two-flop sync plus the state update
    sequence s_por_held; !powerOnResetPin_b [*5]; endsequence
    sequence s_exc_once; nmiExcStart ##1 !nmiExcStart; endsequence
    property p_okay; hresp == 1'b0; endproperty
    property p_read_wait; !hreadyout |=> hreadyout; endproperty
    property p_enter; $fell(chipClkEn) |-> standbyActive && !oscEnable; endproperty
    property p_halt; standbyActive && !oscEnable |-> !wdtClkEn && !chipClkEn; endproperty
    property p_settle; standbyActive && oscEnable |-> wdtClkEn && !chipClkEn; endproperty
    property p_exit; $fell(standbyActive) |-> chipClkEn && oscEnable; endproperty
    property p_exc; nmiExcStart |-> chipClkEn && !standbyActive; endproperty
    property p_exc_pulse; nmiExcStart |-> s_exc_once; endproperty
    property p_por; s_por_held |-> !standbyActive && chipClkEn; endproperty
    a_okay: assert property (p_okay) else $error("bus response not OKAY");
    a_read_wait: assert property (p_read_wait) else $error("wait state too long");
    a_enter: assert property (p_enter) else $error("chip clock off outside standby");
    a_halt: assert property (p_halt) else $error("clock running in standby");
    a_settle: assert property (p_settle) else $error("settling clock leaks");
    a_exit: assert property (p_exit) else $error("exit without chip clock");
    a_exc: assert property (p_exc) else $error("exception before clock feed");
    a_exc_pulse: assert property (p_exc_pulse) else $error("exception pulse too long");
    a_por: assert property (p_por) else $error("reset pin left standby on");
endmodule

bind ses_sequencer ses_sequencer_asserts i_ses_sequencer_asserts (.clk_sys(clk_sys),
    .rst_b(rst_b), .hreadyout(hreadyout), .hresp(hresp), .oscEnable(oscEnable),
    .wdtClkEn(wdtClkEn), .chipClkEn(chipClkEn), .standbyActive(standbyActive),
    .nmiExcStart(nmiExcStart), .powerOnResetPin_b(powerOnResetPin_b));

// [bench/ses_sequencer_test.sv]
// Self-checking bench for the standby exit sequencer
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR %0t got %h expected %h", $time, g, e); end end
module ses_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst_b, hsel, hwrite, pol, fire, por, mres, hreadyout, hresp;
    logic        nmiPin, powerOnResetPin_b, manualResetPin_b, oscEnable, wdtClkEn;
    logic        chipClkEn, standbyActive, nmiExcStart, irq;
    logic [31:0] haddr, hwdata, hrdata, portOut, pinFuncOut;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          err_count = 0, n_compared = 0;
    ses_sequencer i_ses_sequencer (.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .nmiPin(nmiPin), .powerOnResetPin_b(powerOnResetPin_b),
        .manualResetPin_b(manualResetPin_b), .oscEnable(oscEnable), .wdtClkEn(wdtClkEn),
        .chipClkEn(chipClkEn), .standbyActive(standbyActive), .nmiExcStart(nmiExcStart),
        .irq(irq), .portOut(portOut), .pinFuncOut(pinFuncOut));
    ses_pin_src i_ses_pin_src (.clk_sys(clk_sys), .pol(pol), .fire(fire), .por(por),
        .mres(mres), .nmiPin(nmiPin), .powerOnResetPin_b(powerOnResetPin_b),
        .manualResetPin_b(manualResetPin_b));
    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic addr(input logic [7:0] a, input logic w);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr(a, 1'b1);
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        addr(a, 1'b0);
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        `CHK(hrdata, e)
    endtask
    // Preloading the counter near wrap keeps the settling wait to a few ticks
    task automatic enter();
        wr(ses_pkg::OFF_WDT_CNT, 32'h0000_00fe);
        wr(ses_pkg::OFF_CMD, 32'h0000_0001);
        @(posedge clk_sys);
        `CHK(standbyActive, 1'b1)
        `CHK(oscEnable, 1'b0)
    endtask
    task automatic conclude();
        $display("Compared %0d, errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        err_count++;
        conclude();
    end
    initial begin
        {hsel, hwrite, pol, fire, por, mres, rst_b} = 7'h00;
        {haddr, hwdata, htrans} = 66'h0;
        hsize = 3'h2;
        repeat (4) @(posedge clk_sys);
        rst_b <= 1'b1;
        `CHK(chipClkEn, 1'b1)
        rd(ses_pkg::OFF_STBY_CTRL, ses_pkg::RST_WORD);
        rd(8'h3c, 32'h0000_0000);
        wr(ses_pkg::OFF_PORT_DATA, 32'h1234_abcd);
        wr(ses_pkg::OFF_PIN_FUNC, 32'h00c0_ffee);
        wr(ses_pkg::OFF_CMD, 32'h0000_0001);
        @(posedge clk_sys);
        `CHK(standbyActive, 1'b0)
        wr(ses_pkg::OFF_STBY_CTRL, 32'h0000_0001);
        wr(ses_pkg::OFF_IRQ_MASK, 32'h0000_0002);
        wr(ses_pkg::OFF_WDT_CSR, 32'h0000_0041);
        for (int p = 0; p < 2; p++) begin
            wr(ses_pkg::OFF_INT_CTRL, p);
            pol <= p[0];
            repeat (4) @(posedge clk_sys);
            wr(ses_pkg::OFF_IRQ_STAT, 32'h0000_000f);
            enter();
            repeat (20) @(posedge clk_sys);
            `CHK(oscEnable, 1'b0)
            fire <= 1'b1;
            do @(posedge clk_sys); while (oscEnable !== 1'b1);
            `CHK(chipClkEn, 1'b0)
            `CHK(wdtClkEn, 1'b1)
            do @(posedge clk_sys); while (nmiExcStart !== 1'b1);
            `CHK(chipClkEn, 1'b1)
            fire <= 1'b0;
            rd(ses_pkg::OFF_IRQ_STAT, 32'h0000_0002);
            `CHK(irq, 1'b1)
            rd(ses_pkg::OFF_WDT_CSR, 32'h0000_0001);
            rd(ses_pkg::OFF_PORT_DATA, 32'h1234_abcd);
            rd(ses_pkg::OFF_PIN_FUNC, 32'h00c0_ffee);
            rd(ses_pkg::OFF_STBY_CTRL, 32'h0000_0001);
            `CHK(pinFuncOut, 32'h00c0_ffee)
        end
        wr(ses_pkg::OFF_IRQ_MASK, 32'h0000_0000);
        repeat (2) @(posedge clk_sys);
        `CHK(irq, 1'b0)
        wr(ses_pkg::OFF_IRQ_STAT, 32'h0000_0002);
        rd(ses_pkg::OFF_IRQ_STAT, 32'h0000_0000);
        enter();
        mres <= 1'b1;
        repeat (20) @(posedge clk_sys);
        mres <= 1'b0;
        `CHK(standbyActive, 1'b0)
        repeat (4) @(posedge clk_sys);
        rd(ses_pkg::OFF_PORT_DATA, 32'h1234_abcd);
        rd(ses_pkg::OFF_IRQ_STAT, 32'h0000_0008);
        enter();
        wr(ses_pkg::OFF_CMD, 32'h0000_0002);
        @(posedge clk_sys);
        `CHK(standbyActive, 1'b0)
        enter();
        por <= 1'b1;
        repeat (20) @(posedge clk_sys);
        `CHK(standbyActive, 1'b0)
        `CHK(chipClkEn, 1'b1)
        por <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd(ses_pkg::OFF_PORT_DATA, 32'h0000_0000);
        `CHK(portOut, 32'h0000_0000)
        conclude();
    end
endmodule
